// ### design/kgi_consts.vh
// Purpose: constants for the key scanner and pin interrupt block
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register access
// Notes: offsets are byte addresses
`ifndef KGI_CONSTS_VH
`define KGI_CONSTS_VH
`define KGI_CLK_HZ          200000000
`define KGI_TICK_MS         1
`define KGI_TICK_CYCLES     ((`KGI_CLK_HZ / 1000) * `KGI_TICK_MS)
`define KGI_OFS_KBD_CTRL    8'h00
`define KGI_OFS_PIN_EN      8'h04
`define KGI_OFS_DEBOUNCE    8'h08
`define KGI_OFS_SRC_SEL     8'h0C
`define KGI_OFS_PIN_CTRL    8'h10
`define KGI_OFS_IRQ_STAT    8'h14
`define KGI_OFS_IRQ_MASK    8'h18
`define KGI_OFS_PIN_VALUE   8'h1C
`define KGI_KC_LEVEL        0
`define KGI_KC_REL          1
`define KGI_KC_REP_LSB      2
`define KGI_DB_EN_KBD       6
`define KGI_DB_EN_LSB       7
`define KGI_PC_POL_LSB      0
`define KGI_PC_EDGE_LSB     8
`define KGI_RST_KBD_CTRL    32'h00000000
`define KGI_RST_DEBOUNCE    32'h00000000
`endif

// ### design/kgi_top.v
// Purpose: key scanner plus five debounced pin interrupt generators
// Assumes: pins asynchronous to sys_clk; AHB-Lite single word transfers
// Notes on behaviour
// R1 - level 0: falling enabled pin starts scanner
// R2 - detection loads debounce time, counts per ms
// R3 - zero with key held: irq, reload repeat
// R4 - release enabled: new debounce then irq
// R5 - scanner debounce disable skips delay
// R6 - repeat interval zero stops repeats
// R7 - release enable zero: no release irq
// R8 - twelve pin enables gate key detection
// R9 - debounce time 0 to 63 ms
// R10 - five generators, own selector and line
// R11 - polarity 0: rising selected pin detects
// R12 - generator irq only if still detected
// R13 - per generator debounce disable bypasses delay
// R14 - flag stays until software clears it
// R15 - edge mode: cleared waits for inactive edge
// R16 - software inverts polarity to catch both edges
// R17 - software reads pin values to find key
// R18 - level mode: cleared returns idle, retriggers
// R19 - ms prescaler; reset clears timers, flags
//
// Register access over AHB-Lite and the register offsets were decided locally.
`include "kgi_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module kgi_top #(
    parameter integer NPINS     = 12,
    parameter integer NGEN      = 5,
    parameter integer TICK_CYC  = `KGI_TICK_CYCLES
) (
    input  wire             sys_clk,
    input  wire             rstn,
    input  wire             hsel,
    input  wire [31:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output reg  [31:0]      hrdata,
    output reg              hreadyout,
    output reg              hresp,
    input  wire [NPINS-1:0] pin_in,
    output reg              keyboard_irq,
    output reg  [NGEN-1:0]  pin_irq_line,
    output reg              irq
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_DEB  = 2'd1;
    localparam [1:0] S_HELD = 2'd2;
    localparam [1:0] S_REL  = 2'd3;
    localparam [1:0] G_IDLE = 2'd0;
    localparam [1:0] G_DEB  = 2'd1;
    localparam [1:0] G_SET  = 2'd2;
    localparam [1:0] G_WAIT = 2'd3;
    localparam integer SW   = NGEN + 1;

    // pin synchronisers
    reg [NPINS-1:0] pin_s1_q;
    reg [NPINS-1:0] pin_s2_q;
    reg [NPINS-1:0] pin_prev_q;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // pins idle high on pull-ups, so no false edge after reset
            pin_s1_q   <= {NPINS{1'b1}};
            pin_s2_q   <= {NPINS{1'b1}};
            pin_prev_q <= {NPINS{1'b1}};
        end else begin
            pin_s1_q   <= pin_in;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // millisecond tick
    reg [31:0] pre_q;
    reg        tick_q;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_q  <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (pre_q == TICK_CYC - 1) begin
            pre_q  <= 32'h00000000; // R19
            tick_q <= 1'b1;
        end else begin
            pre_q  <= pre_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    // registers
    reg [31:0]      kbd_ctrl_q;
    reg [NPINS-1:0] pin_en_q;
    reg [31:0]      deb_q;
    reg [19:0]      src_sel_q;
    reg [15:0]      pin_ctrl_q;
    reg [SW-1:0]    stat_q;
    reg [SW-1:0]    mask_q;
    reg             wr_ph_q;
    reg [7:0]       wr_addr_q;
    wire            kbd_level = kbd_ctrl_q[`KGI_KC_LEVEL];
    wire            kbd_rel   = kbd_ctrl_q[`KGI_KC_REL];
    wire [5:0]      key_rep   = kbd_ctrl_q[`KGI_KC_REP_LSB +: 6];
    wire [5:0]      deb_time  = deb_q[5:0]; // R9
    wire            kbd_db_en = deb_q[`KGI_DB_EN_KBD];
    wire            addr_ph   = hsel & hready & htrans[1];
    wire            stat_wr   = wr_ph_q & (wr_addr_q == `KGI_OFS_IRQ_STAT);

    // key scanner
    wire [NPINS-1:0] act_now  = kbd_level ? pin_s2_q : ~pin_s2_q;
    wire [NPINS-1:0] act_prev = kbd_level ? pin_prev_q : ~pin_prev_q;
    wire key_edge = |(act_now & ~act_prev & pin_en_q); // R1 R8
    wire key_hit  = |(act_now & pin_en_q);             // R8
    reg  [1:0] ks_q;
    reg  [5:0] ktmr_q;
    reg        kev_q;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ks_q   <= S_IDLE;
            ktmr_q <= 6'h00;
            kev_q  <= 1'b0;
        end else begin
            kev_q <= 1'b0;
            case (ks_q)
                S_IDLE: begin
                    if (key_edge) begin
                        ks_q   <= S_DEB;
                        ktmr_q <= kbd_db_en ? deb_time : 6'h00; // R2 R5
                    end
                end
                S_DEB: begin
                    if (!key_hit) begin
                        ks_q <= S_IDLE;
                    end else if (ktmr_q == 6'h00) begin
                        kev_q  <= 1'b1; // R3
                        ks_q   <= S_HELD;
                        ktmr_q <= key_rep; // R3
                    end else if (tick_q) begin
                        ktmr_q <= ktmr_q - 6'h01; // R2
                    end
                end
                S_HELD: begin
                    if (!key_hit) begin
                        if (kbd_rel) begin
                            ks_q   <= S_REL; // R4
                            ktmr_q <= kbd_db_en ? deb_time : 6'h00; // R4 R5
                        end else begin
                            ks_q <= S_IDLE; // R7
                        end
                    end else if (key_rep != 6'h00) begin // R6
                        if (ktmr_q == 6'h00) begin
                            kev_q  <= 1'b1; // R3
                            ktmr_q <= key_rep;
                        end else if (tick_q) begin
                            ktmr_q <= ktmr_q - 6'h01;
                        end
                    end
                end
                S_REL: begin
                    if (ktmr_q == 6'h00) begin
                        kev_q <= 1'b1; // R4
                        ks_q  <= S_IDLE;
                    end else if (tick_q) begin
                        ktmr_q <= ktmr_q - 6'h01;
                    end
                end
                default: ks_q <= S_IDLE;
            endcase
        end
    end

    // pin interrupt generators
    wire [NGEN-1:0] gev;
    genvar g;
    generate
        for (g = 0; g < NGEN; g = g + 1) begin : gen_pin
            reg  [1:0] st_q;
            reg  [5:0] tmr_q;
            reg        ev_q;
            wire [3:0] sel  = src_sel_q[4*g +: 4]; // R10
            wire       pol  = pin_ctrl_q[`KGI_PC_POL_LSB + g];
            wire       edg  = pin_ctrl_q[`KGI_PC_EDGE_LSB + g];
            wire       den  = deb_q[`KGI_DB_EN_LSB + g];
            wire       lvl  = pin_s2_q[sel] ^ pol;
            wire       lvlp = pin_prev_q[sel] ^ pol;
            wire       hit  = lvl;
            wire       clr  = stat_wr & hwdata[g+1];
            assign gev[g] = ev_q;
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    st_q  <= G_IDLE;
                    tmr_q <= 6'h00;
                    ev_q  <= 1'b0;
                end else begin
                    ev_q <= 1'b0;
                    case (st_q)
                        G_IDLE: begin
                            if (lvl & (~lvlp | ~edg)) begin // R11 R18
                                st_q  <= G_DEB;
                                tmr_q <= den ? deb_time : 6'h00; // R12 R13
                            end
                        end
                        G_DEB: begin
                            if (!hit) begin
                                st_q <= G_IDLE;
                            end else if (tmr_q == 6'h00) begin
                                ev_q <= 1'b1; // R12
                                st_q <= G_SET;
                            end else if (tick_q) begin
                                tmr_q <= tmr_q - 6'h01;
                            end
                        end
                        G_SET: begin
                            if (clr) begin // R14
                                st_q <= edg ? G_WAIT : G_IDLE; // R15 R18
                            end
                        end
                        G_WAIT: begin
                            if (!hit) begin
                                st_q <= G_IDLE; // R15 R16
                            end
                        end
                        default: st_q <= G_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // bus slave, status and interrupt
    wire [SW-1:0] ev_all = {gev, kev_q};
    reg  [31:0]   rd_d;
    always @* begin
        case (haddr[7:0])
            `KGI_OFS_KBD_CTRL:  rd_d = kbd_ctrl_q;
            `KGI_OFS_PIN_EN:    rd_d = {{(32-NPINS){1'b0}}, pin_en_q};
            `KGI_OFS_DEBOUNCE:  rd_d = deb_q;
            `KGI_OFS_SRC_SEL:   rd_d = {12'h000, src_sel_q};
            `KGI_OFS_PIN_CTRL:  rd_d = {16'h0000, pin_ctrl_q};
            `KGI_OFS_IRQ_STAT:  rd_d = {{(32-SW){1'b0}}, stat_q};
            `KGI_OFS_IRQ_MASK:  rd_d = {{(32-SW){1'b0}}, mask_q};
            `KGI_OFS_PIN_VALUE: rd_d = {{(32-NPINS){1'b0}}, pin_s2_q}; // R17
            default:            rd_d = 32'h00000000;
        endcase
    end
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            kbd_ctrl_q   <= `KGI_RST_KBD_CTRL;
            pin_en_q     <= {NPINS{1'b0}};
            deb_q        <= `KGI_RST_DEBOUNCE;
            src_sel_q    <= 20'h00000;
            pin_ctrl_q   <= 16'h0000;
            stat_q       <= {SW{1'b0}};
            mask_q       <= {SW{1'b0}};
            wr_ph_q      <= 1'b0;
            wr_addr_q    <= 8'h00;
            hrdata       <= 32'h00000000;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            keyboard_irq <= 1'b0;
            pin_irq_line <= {NGEN{1'b0}};
            irq          <= 1'b0;
        end else begin
            wr_ph_q   <= addr_ph & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_ph & ~hwrite) begin
                hrdata <= rd_d;
            end
            if (wr_ph_q) begin
                case (wr_addr_q)
                    `KGI_OFS_KBD_CTRL: kbd_ctrl_q <= {24'h000000, hwdata[7:0]};
                    `KGI_OFS_PIN_EN:   pin_en_q   <= hwdata[NPINS-1:0];
                    `KGI_OFS_DEBOUNCE: deb_q      <= {20'h00000, hwdata[11:0]};
                    `KGI_OFS_SRC_SEL:  src_sel_q  <= hwdata[19:0];
                    `KGI_OFS_PIN_CTRL: pin_ctrl_q <= hwdata[15:0];
                    `KGI_OFS_IRQ_MASK: mask_q     <= hwdata[SW-1:0];
                    default: ;
                endcase
            end
            // set wins over write-one clear
            stat_q <= (stat_q & ~(stat_wr ? hwdata[SW-1:0] : {SW{1'b0}})) | ev_all; // R14
            keyboard_irq <= stat_q[0];
            pin_irq_line <= stat_q[SW-1:1]; // R14
            irq          <= |(stat_q & mask_q);
        end
    end
endmodule // kgi_top
`default_nettype wire

// ### sim/kgi_chk_checker.sv
// Purpose: port checker for kgi_top
// Assumes: hready fed from hreadyout
// Notes: bound at the foot
`timescale 1ns/1ps
`default_nettype none
module kgi_chk #(parameter int NPINS = 12, parameter int NGEN = 5) (
    input wire logic             sys_clk,
    input wire logic             rstn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic             keyboard_irq,
    input wire logic [NGEN-1:0]  pin_irq_line,
    input wire logic             irq
);
    logic [5:0] clr_q, mk_q;
    logic       wc_q, wm_q, ru_q, rm_q, rp_q;
    wire logic  tk = hsel & hready & htrans[1];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {clr_q, mk_q, wc_q, wm_q, ru_q, rm_q, rp_q} <= '0;
        end else begin
            wc_q  <= tk & hwrite & (haddr[7:0] == 8'h14);
            wm_q  <= tk & hwrite & (haddr[7:0] == 8'h18);
            ru_q  <= tk & !hwrite & (haddr[7:5] != 3'h0);
            rm_q  <= tk & !hwrite & (haddr[7:0] == 8'h18);
            rp_q  <= tk & !hwrite & (haddr[7:0] == 8'h1C);
            clr_q <= wc_q ? hwdata[5:0] : 6'h00;
            if (wm_q) mk_q <= hwdata[5:0];
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    a_unmapped_zero: assert property (ru_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_mask_back: assert property (rm_q |-> hrdata[5:0] == $past(mk_q))
        else $error("mask readback wrong");
    a_irq_exact: assert property (irq == |({pin_irq_line, keyboard_irq} & $past(mk_q)))
        else $error("irq not status and mask");
    a_kbd_sticky: assert property ($fell(keyboard_irq) |-> $past(clr_q[0]))
        else $error("keyboard flag fell uncleared");
    a_pin_sticky: assert property
        (($past(pin_irq_line) & ~pin_irq_line & ~$past(clr_q[5:1])) == 5'h00)
        else $error("pin flag fell uncleared");
    a_pin_value: assert property (rp_q && $past(pin_in) == $past(pin_in, 4)
        && $past(pin_in, 2) == $past(pin_in, 3) && $past(pin_in) == $past(pin_in, 2)
        |-> hrdata[NPINS-1:0] == $past(pin_in)) else $error("pin value read wrong");
    c_kbd: cover property ($rose(keyboard_irq));
    c_gen: cover property ($rose(|pin_irq_line));
    c_irq: cover property ($rose(irq));
endmodule // kgi_chk
bind kgi_top kgi_chk #(.NPINS(NPINS), .NGEN(NGEN)) kgi_chk_inst (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .keyboard_irq(keyboard_irq), .pin_irq_line(pin_irq_line), .irq(irq));
`default_nettype wire

// ### sim/kgi_keys.sv
// Purpose: keys on pull-up pins
// Assumes: press high holds key, pin low
// Notes: four cycles of chatter per change
`timescale 1ns/1ps
`default_nettype none
module kgi_keys #(parameter int N = 12) (
    input  wire logic         sys_clk,
    input  wire logic [N-1:0] press,
    output var  logic [N-1:0] pin
);
    logic [N-1:0] last_q = '0;
    logic [2:0]   chat_q [N];
    initial begin
        pin = '1;
        foreach (chat_q[i]) chat_q[i] = 3'h0;
    end
    always @(posedge sys_clk) begin
        for (int i = 0; i < N; i++) begin
            if (press[i] !== last_q[i]) chat_q[i] <= 3'h4;
            else if (chat_q[i] != 3'h0) chat_q[i] <= chat_q[i] - 3'h1;
            pin[i] <= (chat_q[i] != 3'h0) ? ~pin[i] : ~press[i];
        end
        last_q <= press;
    end
endmodule // kgi_keys
`default_nettype wire

// ### sim/kgi_top_tb.sv
// Purpose: self-checking bench for kgi_top
// Assumes: tick shortened to T cycles
// Notes: keys model drives the pins
`include "kgi_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module kgi_top_tb;
    localparam int T = 20;
    localparam int D = 3;
    logic        sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0, hwdata = 32'h0, rd;
    logic [11:0] press   = 12'h000;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, keyboard_irq, irq;
    wire  [4:0]  pin_irq_line;
    wire  [11:0] pin_in;
    wire  [5:0]  fl = {pin_irq_line, keyboard_irq};
    int          fail_count = 0, total_checks = 0, cyc = 0, g, p, k, e, lo, hi;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            close_out();
        end
    end
    kgi_top #(.TICK_CYC(T)) kgi_top_inst (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .keyboard_irq(keyboard_irq), .pin_irq_line(pin_irq_line), .irq(irq));
    kgi_keys kgi_keys_inst (.sys_clk(sys_clk), .press(press), .pin(pin_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic await(input int b, input int l, input int h, input logic x);
        int n;
        n = 1;
        @(posedge sys_clk);
        #1;
        while (fl[b] !== 1'b1 && n < h) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(fl[b], x);
        if (x) check(n >= l, 1'b1);
    endtask
    initial begin
        p = $urandom(32'hF01E);
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        #1 check(fl, 6'h00);
        repeat (2) @(posedge sys_clk);
        xfer(`KGI_OFS_KBD_CTRL, 1'b0, 32'h0);
        check(rd, `KGI_RST_KBD_CTRL);
        xfer(`KGI_OFS_DEBOUNCE, 1'b0, 32'h0);
        check(rd, `KGI_RST_DEBOUNCE);
        wr(8'h40, 32'hFFFFFFFF);
        xfer(8'h40, 1'b0, 32'h0);
        check(rd, 32'h0);
        check(fl, 6'h3E);
        press <= 12'($urandom);
        repeat (12) @(posedge sys_clk);
        xfer(`KGI_OFS_PIN_VALUE, 1'b0, 32'h0);
        check(rd, {20'h0, ~press});
        press <= 12'h000;
        wr(`KGI_OFS_IRQ_MASK, 32'h3F);
        for (g = 0; g < 5; g++) begin
            p = $urandom % 12;
            e = g % 2;
            lo = (g == 4) ? 0 : (D - 1) * T - 8;
            hi = (g == 4) ? 16 : (D + 1) * T + 20;
            wr(8'h0C, p << (g * 4));
            wr(8'h10, e << (g + 8));
            wr(8'h08, D | ((g < 4 ? 32'h1 : 32'h0) << (g + 7)));
            press[p] <= 1'b1;
            repeat (10) @(posedge sys_clk);
            wr(8'h14, 32'h3F);
            press[p] <= 1'b0;
            await(g + 1, lo, hi, 1'b1);
            wr(8'h14, 32'h1 << (g + 1));
            await(g + 1, 0, hi, e ? 1'b0 : 1'b1);
            if (e) begin
                wr(8'h10, 32'h101 << g);
                press[p] <= 1'b1;
                await(g + 1, lo, hi, 1'b1);
            end
        end
        k = $urandom % 12;
        press <= 12'h000;
        wr(8'h04, (32'($urandom) | (32'h1 << k)) & ~(32'h1 << ((k + 1) % 12)) & 32'hFFF);
        wr(8'h00, 32'h0A);
        wr(8'h08, 32'h7F);
        wr(8'h14, 32'h3F);
        press[k] <= 1'b1;
        await(0, 62 * T - 8, 64 * T + 20, 1'b1);
        wr(8'h14, 32'h1);
        await(0, T - 8, 3 * T + 20, 1'b1);
        wr(8'h14, 32'h1);
        press[k] <= 1'b0;
        await(0, 62 * T - 8, 64 * T + 20, 1'b1);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h14, 32'h1);
        press[k] <= 1'b1;
        await(0, 0, 16, 1'b1);
        wr(8'h14, 32'h1);
        await(0, 0, 4 * T, 1'b0);
        press[k] <= 1'b0;
        await(0, 0, 4 * T, 1'b0);
        press[(k + 1) % 12] <= 1'b1;
        await(0, 0, 4 * T, 1'b0);
        press[k] <= 1'b1;
        await(0, 0, 16, 1'b1);
        wr(`KGI_OFS_IRQ_MASK, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1 check(irq, 1'b0);
        wr(`KGI_OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge sys_clk);
        #1 check({irq, keyboard_irq}, 2'h3);
        close_out();
    end
endmodule // kgi_top_tb
`default_nettype wire
